//--- src/hmsa_arbiter.sv
`timescale 1ns/10ps
// Overview of operation
// - Target select high picks config register, low picks memory by select bits.
// - Config register is reachable from the host port only, never the CPU.
// - Bus granted rests low after reset, high only while host owns buses.
// - Lock low after grant keeps the CPU stalled after grant falls, until lock goes high.
// - Access starts when remote select and read or write are both low.
// - Write pending resets high, falls while latched write data awaits service.
// - Transfer ack resets high, falls on request, rises when transfer completes.
// - In latched write mode ack toggles only for a second access during a write.
// - Wait low stretches host accesses and CPU instruction cycles.
// - Config bits: select[1:0], run, latched write, latched read, fast, step, status.
// - Internal T-state enable is the crystal divided by two or undivided.
// - Grant when CPU off data memory, at most one instruction delay unless locked out.
// - Arbitration lasts at least one T-state, longer on CPU access or lock out.
// - Target select captured once at first T-state after start, held all access.
// - Internal strobe falls one T-state after grant, rises one clock after transfer ack.
// - Read strobe drives memory read; write strobe loads PC, config and write lines.
// - Access lasts at least two T-states, plus wait states and wait input.
// - Rising transfer ack ends access and marks read data valid for host.
// - Grant falls one T-state after ack rises; termination at least one T-state.
// - Select encodes data 00, instruction 01, PC low 10, PC high 11.
module hmsa_arbiter
    import hmsa_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Clock divide select
    input  wire logic       clock_divide_select,
    // Host control pins
    input  wire logic       remote_select_n,
    input  wire logic       host_read_n,
    input  wire logic       host_write_n,
    input  wire logic       target_select,
    input  wire logic       lock_n,
    input  wire logic       wait_n,
    // Host data path
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    // CPU side
    input  wire logic       cpu_dmem_busy,
    input  wire logic       cpu_instr_end,
    input  wire logic       lock_out_host,
    input  wire logic [1:0] dmem_wait_states,
    input  wire logic [1:0] imem_wait_states,
    input  wire logic [7:0] target_read_data,
    output logic            cpu_stall,
    output logic            cpu_wait,
    // Handshake outputs
    output logic            bus_granted_out,
    output logic            transfer_ack,
    output logic            write_pending_n,
    output logic            int_read_n,
    output logic            int_write_n,
    output logic            mem_read_n,
    output logic            mem_write_n,
    output logic            instr_mem_write,
    output logic            pc_load,
    output logic [1:0]      access_target,
    output logic            access_is_config,
    // Configuration register
    output logic [7:0]      host_port_config
);

    hmsa_state_t state_reg;
    logic       tick_reg;
    logic       req_meta_reg;
    logic       req_sync_reg;
    logic       cmd_reg;
    logic       is_write_reg;
    logic [3:0] cnt_reg;
    logic [3:0] access_len;
    logic       host_req;
    logic       req_new;
    logic       req_served_reg;
    logic       lock_held_reg;
    logic       lw_gap_reg;

    // Raw request: order of pin arrival does not matter
    assign host_req = ~remote_select_n & (~host_read_n | ~host_write_n);

    // T-state enable; divide by two uses every second edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tick_reg <= 1'b0;
        end else if (clock_divide_select) begin
            tick_reg <= ~tick_reg;
        end else begin
            tick_reg <= 1'b1;
        end
    end

    // Two stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
        end else begin
            req_meta_reg <= host_req;
            req_sync_reg <= req_meta_reg;
        end
    end

    // A serviced request must drop before it may start another access
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            req_served_reg <= 1'b0;
        end else if (state_reg == HMSA_TERM) begin
            req_served_reg <= 1'b1;
        end else if (!req_sync_reg) begin
            req_served_reg <= 1'b0;
        end
    end
    assign req_new = req_sync_reg & ~req_served_reg;

    // Access phase length: programmed waits apply to memories only
    always_comb begin
        access_len = {2'b00, ACCESS_MIN_T};
        if (!cmd_reg && host_port_config[CFG_MS_HI:CFG_MS_LO] == HMSA_SEL_DMEM) begin
            access_len = {2'b00, ACCESS_MIN_T} + {2'b00, dmem_wait_states};
        end else if (!cmd_reg && host_port_config[CFG_MS_HI:CFG_MS_LO] == HMSA_SEL_IMEM) begin
            access_len = {2'b00, ACCESS_MIN_T} + {2'b00, imem_wait_states};
        end
    end

    // Phase sequencer, advances on T-state ticks
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg    <= HMSA_IDLE;
            cnt_reg      <= 4'h0;
            cmd_reg      <= 1'b0;
            is_write_reg <= 1'b0;
        end else if (tick_reg) begin
            case (state_reg)
                HMSA_IDLE: begin
                    if (req_new) begin
                        state_reg    <= HMSA_ARB;
                        cmd_reg      <= target_select;
                        is_write_reg <= ~host_write_n;
                    end
                end
                HMSA_ARB: begin
                    // Wait for CPU off data memory, break in at instruction end
                    if (!lock_out_host && (!cpu_dmem_busy || cpu_instr_end)) begin
                        state_reg <= HMSA_GRANT;
                    end
                end
                HMSA_GRANT: begin
                    state_reg <= HMSA_ACCESS;
                    cnt_reg   <= 4'h1;
                end
                HMSA_ACCESS: begin
                    if (wait_n && cnt_reg >= access_len) begin
                        state_reg <= HMSA_TERM;
                        cnt_reg   <= 4'h0;
                    end else if (wait_n) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                HMSA_TERM: begin
                    state_reg <= HMSA_DONE;
                end
                HMSA_DONE: begin
                    // Buffered modes return to idle at once; otherwise wait until host releases request
                    if (host_port_config[CFG_LR] || host_port_config[CFG_LW] || !req_sync_reg) begin
                        state_reg <= HMSA_IDLE;
                    end
                end
                default: begin
                    state_reg <= HMSA_IDLE;
                end
            endcase
        end
    end

    // Grant output and CPU stall; lock keeps CPU out after grant
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_granted_out <= 1'b0;
            cpu_stall       <= 1'b0;
            cpu_wait        <= 1'b0;
            lock_held_reg   <= 1'b0;
        end else begin
            // Grant drops one T-state after the acknowledge rises
            bus_granted_out <= (state_reg == HMSA_ACCESS) || (state_reg == HMSA_GRANT)
                               || (state_reg == HMSA_TERM && !tick_reg);
            // Lock taken under grant keeps the CPU out until lock is released
            lock_held_reg <= !lock_n && (lock_held_reg || bus_granted_out);
            cpu_stall <= (state_reg != HMSA_IDLE && state_reg != HMSA_ARB)
                         || (!lock_n && (bus_granted_out || lock_held_reg));
            cpu_wait  <= ~wait_n;
        end
    end

    // Transfer ack falls on request, rises at end of access
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            transfer_ack <= 1'b1;
        end else if (state_reg == HMSA_ACCESS && tick_reg && wait_n && cnt_reg >= access_len) begin
            transfer_ack <= 1'b1;
        end else if (host_port_config[CFG_LW]) begin
            // Latched write: only a second access during a pending write drops it
            transfer_ack <= ~(host_req && state_reg != HMSA_IDLE && !write_pending_n
                              && lw_gap_reg);
        end else if (req_new && state_reg == HMSA_IDLE) begin
            transfer_ack <= 1'b0;
        end
    end

    // Host let go of the pending write; a new request is then a second access
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lw_gap_reg <= 1'b0;
        end else if (write_pending_n) begin
            lw_gap_reg <= 1'b0;
        end else if (!host_req) begin
            lw_gap_reg <= 1'b1;
        end
    end

    // Write pending flag for latched write configuration
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            write_pending_n <= 1'b1;
        end else if (host_port_config[CFG_LW] && state_reg == HMSA_IDLE && req_new
                     && !host_write_n) begin
            write_pending_n <= 1'b0;
        end else if (state_reg == HMSA_TERM) begin
            write_pending_n <= 1'b1;
        end
    end

    // Internal strobes and derived memory lines
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            int_read_n      <= 1'b1;
            int_write_n     <= 1'b1;
            mem_read_n      <= 1'b1;
            mem_write_n     <= 1'b1;
            instr_mem_write <= 1'b0;
            pc_load         <= 1'b0;
        end else begin
            int_read_n  <= ~(state_reg == HMSA_ACCESS && !is_write_reg);
            int_write_n <= ~(state_reg == HMSA_ACCESS && is_write_reg);
            mem_read_n  <= ~(state_reg == HMSA_ACCESS && !is_write_reg && !cmd_reg);
            mem_write_n <= ~(state_reg == HMSA_ACCESS && is_write_reg && !cmd_reg
                             && host_port_config[CFG_MS_HI:CFG_MS_LO] == HMSA_SEL_DMEM);
            instr_mem_write <= state_reg == HMSA_ACCESS && is_write_reg && !cmd_reg
                               && host_port_config[CFG_MS_HI:CFG_MS_LO] == HMSA_SEL_IMEM;
            pc_load <= state_reg == HMSA_ACCESS && is_write_reg && !cmd_reg
                       && host_port_config[CFG_MS_HI];
        end
    end

    // Target routing and read data to the host
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            access_is_config <= 1'b0;
            access_target    <= HMSA_SEL_IMEM;
            host_data_out    <= CFG_RESET;
        end else begin
            access_is_config <= cmd_reg;
            access_target    <= host_port_config[CFG_MS_HI:CFG_MS_LO];
            // Config contents sit on the bus by default between accesses
            host_data_out <= (state_reg == HMSA_ACCESS && !cmd_reg) ? target_read_data
                                                                    : host_port_config;
        end
    end

    // Config register: written only from the host port at end of access
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            host_port_config <= CFG_RESET;
        end else if (state_reg == HMSA_ACCESS && tick_reg && wait_n && cnt_reg >= access_len
                     && cmd_reg && is_write_reg) begin
            host_port_config <= host_data_in;
        end
    end

    // Assertions
    sequence s_grant_rise;
        $rose(bus_granted_out);
    endsequence

    AST_GRANT_RESET: assert property (@(posedge clk_sys) srst |=> !bus_granted_out)
        else $error("grant high after reset");
    AST_ACK_RESET: assert property (@(posedge clk_sys) srst |=> transfer_ack)
        else $error("ack low after reset");
    AST_PEND_RESET: assert property (@(posedge clk_sys) srst |=> write_pending_n)
        else $error("write pending low after reset");
    AST_STROBE_AFTER_GRANT: assert property (@(posedge clk_sys) disable iff (srst)
        s_grant_rise |-> ##[0:4] (!int_read_n || !int_write_n))
        else $error("strobe did not follow grant");
    AST_STROBE_NOT_BEFORE: assert property (@(posedge clk_sys) disable iff (srst)
        (!int_read_n || !int_write_n) |-> bus_granted_out)
        else $error("strobe without grant");
    AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(req_sync_reg) |-> $past(host_req, 2))
        else $error("request not two stages");
    AST_NO_GRANT_LOCKOUT: assert property (@(posedge clk_sys) disable iff (srst)
        (state_reg == HMSA_ARB && lock_out_host) |=> state_reg != HMSA_GRANT)
        else $error("grant during lock out");
    AST_LOCK_STALL: assert property (@(posedge clk_sys) disable iff (srst)
        (bus_granted_out && !lock_n) |=> cpu_stall)
        else $error("cpu not stalled under lock");
    AST_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        !(state_reg == HMSA_ACCESS && cmd_reg && is_write_reg) |=> $stable(host_port_config))
        else $error("config changed outside host write");

endmodule : hmsa_arbiter

//--- shared/hmsa_pkg.sv
package hmsa_pkg;
    // Configuration register field positions
    localparam int CFG_MS_LO   = 0;
    localparam int CFG_MS_HI   = 1;
    localparam int CFG_RUN     = 2;
    localparam int CFG_LW      = 3;
    localparam int CFG_LR      = 4;
    localparam int CFG_FBW     = 5;
    localparam int CFG_SS      = 6;
    localparam int CFG_BIS     = 7;
    // Instruction memory is the power-up selection
    localparam logic [7:0] CFG_RESET = 8'h01;

    // Memory select encodings
    typedef enum logic [1:0] {
        HMSA_SEL_DMEM = 2'b00,
        HMSA_SEL_IMEM = 2'b01,
        HMSA_SEL_PCLO = 2'b10,
        HMSA_SEL_PCHI = 2'b11
    } hmsa_sel_t;

    // Access phase states
    typedef enum logic [2:0] {
        HMSA_IDLE   = 3'b000,
        HMSA_ARB    = 3'b001,
        HMSA_GRANT  = 3'b010,
        HMSA_ACCESS = 3'b011,
        HMSA_TERM   = 3'b100,
        HMSA_DONE   = 3'b101
    } hmsa_state_t;

    // Timing in T-states
    localparam logic [1:0] ACCESS_MIN_T = 2'h2;
    localparam logic [1:0] TERM_MIN_T   = 2'h1;
endpackage : hmsa_pkg

//--- sim/hmsa_host_model.sv
`timescale 1ns/10ps
module hmsa_host_model
    import hmsa_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Request lines toward the arbiter
    output logic            remote_select_n,
    output logic            host_read_n,
    output logic            host_write_n,
    output logic            target_select,
    output logic [7:0]      host_data_in,
    // Answers from the arbiter
    input  wire logic       transfer_ack,
    input  wire logic       bus_granted_out,
    input  wire logic       int_read_n,
    input  wire logic       int_write_n,
    input  wire logic [7:0] host_data_out,
    input  wire logic [1:0] access_target,
    input  wire logic       access_is_config
);
    // Results of the last access, read by the bench
    logic [7:0] last_rdata;
    logic [1:0] last_tgt;
    logic       last_cfg;
    logic       saw_rd;
    logic       saw_wr;
    logic       bad_strobe;
    logic       grant_after;
    logic       hung;
    int         last_cyc;

    // Idle host at time zero
    initial begin
        remote_select_n = 1'b1;
        host_read_n     = 1'b1;
        host_write_n    = 1'b1;
        target_select   = 1'b0;
        host_data_in    = 8'h00;
        hung            = 1'b0;
    end

    // One access; request and qualifiers held until the acknowledge is sampled high
    // Latched host: request held four cycles, latches keep data and target
    task automatic access(input logic wr, input logic cmd, input logic [7:0] wdata,
                          input logic nowait = 1'b0);
        logic seen_low;
        begin
            seen_low = 1'b0;
            saw_rd = 1'b0;
            saw_wr = 1'b0;
            bad_strobe = 1'b0;
            last_cyc = 0;
            @(posedge clk_sys);
            target_select   <= cmd;    // Valid with the request, never later
            host_data_in    <= wdata;
            remote_select_n <= 1'b0;
            host_read_n     <= wr;
            host_write_n    <= !wr;
            do begin
                @(posedge clk_sys);
                last_cyc++;
                if (transfer_ack === 1'b0) seen_low = 1'b1;
                if (int_read_n === 1'b0) saw_rd = 1'b1;
                if (int_write_n === 1'b0) saw_wr = 1'b1;
                if ((int_read_n === 1'b0 || int_write_n === 1'b0) && bus_granted_out !== 1'b1)
                    bad_strobe = 1'b1;
                if (int_read_n === 1'b0 || int_write_n === 1'b0) begin
                    last_tgt = access_target;
                    last_cfg = access_is_config;
                end
            end while (nowait ? (last_cyc < 4)
                              : (!(seen_low && transfer_ack === 1'b1) && last_cyc < 400));
            if (last_cyc >= 400) hung = 1'b1;
            last_rdata = host_data_out;
            // Released lines show the inverse, except target and data under nowait, so stale values never pass
            remote_select_n <= 1'b1;
            host_read_n     <= 1'b1;
            host_write_n    <= 1'b1;
            if (!nowait) begin
                target_select <= !cmd;
                host_data_in  <= ~wdata;
            end
            repeat (6) @(posedge clk_sys);
            grant_after = bus_granted_out;
        end
    endtask : access
endmodule : hmsa_host_model

//--- sim/test_hmsa_arbiter.sv
`timescale 1ns/10ps
module test_hmsa_arbiter
    import hmsa_pkg::*;
;
    logic       clk_sys, srst, clock_divide_select, lock_n, wait_n, cpu_dmem_busy;
    logic       cpu_instr_end, lock_out_host, remote_select_n, host_read_n, host_write_n;
    logic       target_select, bus_granted_out, transfer_ack, write_pending_n;
    logic       int_read_n, int_write_n, access_is_config;
    logic [1:0] dmem_wait_states, imem_wait_states, access_target;
    logic [7:0] host_data_in, host_data_out, target_read_data, host_port_config;
    int         bad_count, comparisons, base;
    logic       cpu_stall, cpu_wait, mem_read_n, mem_write_n, instr_mem_write, pc_load;
    logic       clr_seen;
    logic [7:0] seen;

    // Sticky record of strobes: 7 pend, 6 ack, 5 mrd, 4 mwr, 3 iwr, 2 pc, 1 stall, 0 wait
    always @(posedge clk_sys) begin
        if (clr_seen) seen <= 8'h00;
        else seen <= seen | {~write_pending_n, ~transfer_ack, ~mem_read_n, ~mem_write_n,
                             instr_mem_write, pc_load, cpu_stall, cpu_wait};
    end

    task automatic clear_seen;
        clr_seen <= 1'b1;
        @(posedge clk_sys);
        clr_seen <= 1'b0;
    endtask : clear_seen

    hmsa_arbiter dut (.clk_sys(clk_sys), .srst(srst), .clock_divide_select(clock_divide_select),
        .remote_select_n(remote_select_n), .host_read_n(host_read_n),
        .host_write_n(host_write_n), .target_select(target_select), .lock_n(lock_n),
        .wait_n(wait_n), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .cpu_dmem_busy(cpu_dmem_busy), .cpu_instr_end(cpu_instr_end),
        .lock_out_host(lock_out_host), .dmem_wait_states(dmem_wait_states),
        .imem_wait_states(imem_wait_states), .target_read_data(target_read_data),
        .cpu_stall(cpu_stall), .cpu_wait(cpu_wait), .bus_granted_out(bus_granted_out),
        .transfer_ack(transfer_ack), .write_pending_n(write_pending_n),
        .int_read_n(int_read_n), .int_write_n(int_write_n), .mem_read_n(mem_read_n),
        .mem_write_n(mem_write_n), .instr_mem_write(instr_mem_write), .pc_load(pc_load),
        .access_target(access_target),
        .access_is_config(access_is_config), .host_port_config(host_port_config));

    hmsa_host_model host (.clk_sys(clk_sys), .remote_select_n(remote_select_n),
        .host_read_n(host_read_n), .host_write_n(host_write_n),
        .target_select(target_select), .host_data_in(host_data_in),
        .transfer_ack(transfer_ack), .bus_granted_out(bus_granted_out),
        .int_read_n(int_read_n), .int_write_n(int_write_n), .host_data_out(host_data_out),
        .access_target(access_target), .access_is_config(access_is_config));

    // Compare one value, four-state exact
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        report_and_stop();
    end

    initial begin
        bad_count = 0; comparisons = 0;
        srst = 1'b1; clock_divide_select = 1'b0; lock_n = 1'b1; wait_n = 1'b1;
        clr_seen = 1'b1;
        cpu_dmem_busy = 1'b0; cpu_instr_end = 1'b0; lock_out_host = 1'b0;
        dmem_wait_states = 2'h0; imem_wait_states = 2'h0; target_read_data = 8'h00;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        clr_seen <= 1'b0;
        @(posedge clk_sys);
        chk("grant", 8'h00, {7'h0, bus_granted_out});
        chk("ack", 8'h01, {7'h0, transfer_ack});
        chk("wpend", 8'h01, {7'h0, write_pending_n});
        chk("cfg", 8'h01, host_port_config);
        $display("test reset done");
        // Every memory select code: write config, read it back, then route an access
        for (int s = 0; s < 4; s++) begin
            host.access(1'b1, 1'b1, {6'h00, s[1:0]});
            chk("cfg", {6'h00, s[1:0]}, host_port_config);
            host.access(1'b0, 1'b1, 8'hFF);
            chk("cfg_rd", {6'h00, s[1:0]}, host.last_rdata);
            target_read_data <= 8'h3C + 8'(s);
            clear_seen();
            host.access(1'b0, 1'b0, 8'h00);
            chk("mem_rd", 8'h01, {7'h0, seen[5]});
            chk("stall", 8'h01, {7'h0, seen[1]});
            chk("tgt", {6'h00, s[1:0]}, {6'h00, host.last_tgt});
            chk("is_cfg", 8'h00, {7'h0, host.last_cfg});
            chk("rdata", 8'h3C + 8'(s), host.last_rdata);
            chk("rd_strobe", 8'h01, {7'h0, host.saw_rd});
            chk("strobe_grant", 8'h00, {7'h0, host.bad_strobe});
            chk("grant_end", 8'h00, {7'h0, host.grant_after});
            clear_seen();
            host.access(1'b1, 1'b0, 8'h11);
            chk("mem_wr", {7'h0, s == 0}, {7'h0, seen[4]});
            chk("iwr", {7'h0, s == 1}, {7'h0, seen[3]});
            chk("pc_load", {7'h0, s > 1}, {7'h0, seen[2]});
        end
        $display("test select done");
        host.access(1'b1, 1'b1, 8'h00);
        host.access(1'b1, 1'b0, 8'h96);
        chk("wr_strobe", 8'h01, {7'h0, host.saw_wr});
        chk("no_rd", 8'h00, {7'h0, host.saw_rd});
        chk("wpend", 8'h01, {7'h0, write_pending_n});
        host.access(1'b0, 1'b0, 8'h00);
        base = host.last_cyc;
        chk("min_len", 8'h01, {7'h0, base >= 4});
        dmem_wait_states <= 2'h3;
        host.access(1'b0, 1'b0, 8'h00);
        chk("dwait", 8'h01, {7'h0, host.last_cyc >= base + 3});
        dmem_wait_states <= 2'h0;
        clock_divide_select <= 1'b1;
        host.access(1'b0, 1'b0, 8'h00);
        chk("div2", 8'h01, {7'h0, host.last_cyc > base});
        clock_divide_select <= 1'b0;
        $display("test timing done");
        // Wait input held low stretches the access
        clear_seen();
        fork
            host.access(1'b0, 1'b0, 8'h00);
            begin
                @(posedge clk_sys);
                wait_n <= 1'b0;
                repeat (20) @(posedge clk_sys);
                wait_n <= 1'b1;
            end
        join
        chk("wait", 8'h01, {7'h0, host.last_cyc >= 20});
        chk("cpu_wait", 8'h01, {7'h0, seen[0]});
        // Lock taken during an access keeps the CPU stalled until it is released
        lock_n <= 1'b0;
        host.access(1'b0, 1'b0, 8'h00);
        chk("lock_stall", 8'h01, {7'h0, cpu_stall});
        lock_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("lock_free", 8'h00, {7'h0, cpu_stall});
        // Latched write: pending flag low until serviced, acknowledge stays high
        host.access(1'b1, 1'b1, 8'h08);
        clear_seen();
        host.access(1'b1, 1'b0, 8'h5A, 1'b1);
        chk("pend_seen", 8'h01, {7'h0, seen[7]});
        chk("lw_ack", 8'h00, {7'h0, seen[6]});
        chk("lw_mem_wr", 8'h01, {7'h0, seen[4]});
        chk("wpend_end", 8'h01, {7'h0, write_pending_n});
        host.access(1'b1, 1'b1, 8'h00, 1'b1);
        chk("cfg_lw", 8'h00, host_port_config);
        $display("test lock and latch done");
        // Lock-out and CPU data traffic both hold off the grant
        for (int i = 0; i < 2; i++) begin
            fork
                host.access(1'b0, 1'b0, 8'h00);
                begin
                    @(posedge clk_sys);
                    if (i == 0) lock_out_host <= 1'b1;
                    else cpu_dmem_busy <= 1'b1;
                    repeat (25) @(posedge clk_sys);
                    chk("held", 8'h00, {7'h0, bus_granted_out});
                    lock_out_host <= 1'b0;
                    cpu_dmem_busy <= 1'b0;
                end
            join
            chk("held_len", 8'h01, {7'h0, host.last_cyc >= 25});
        end
        $display("test hold done");
        chk("hung", 8'h00, {7'h0, host.hung});
        report_and_stop();
    end
endmodule : test_hmsa_arbiter
